// >>> shared/adv_pkg.sv
// constants for the auto-negotiation advertisement register block
//
// Summary of operation
// - 16-bit advertisement word at address 0x04 forms the transmitted link code word.
// - bit 15 next page, read/write, resets to zero, advertises next-page support.
// - bit 14 reads zero; writes land only while command override is one.
// - bits 12..10 read zero; writes land only while command override is one.
// - bit 13 read/write fault flag, set on local link fault, else takes a high-lane write, else cleared.
// - bit 9 always reads zero in every mode.
// - bits 8..5 advertise 100FD, 100HD, 10FD, 10HD; each resets to one.
// - bits 8..5 read-only when mode pin low, override-gated writable when high.
// - hardware mode, autoneg pin low: no negotiation, pins fix rate and duplex.
// - hardware mode, autoneg pin high: advertise exactly one pin-selected technology.
// - status capability bits always report every supported technology.
// - selector bits 4..0 override-gated, reset to 00001.
// - software mode, autoneg enable zero: control bits fix rate and duplex.
`default_nettype none
package adv_pkg;
  // -------------------------------------------------------------------
  // bus and map
  // -------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADV_OFFSET = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // -------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------
  localparam int NP_BIT = 15;
  localparam int RSVD14_BIT = 14;
  localparam int FAULT_BIT = 13;
  localparam int RSVD_HI = 12;
  localparam int RSVD_LO = 10;
  localparam int T4_BIT = 9;
  localparam int TECH_HI = 8;
  localparam int TECH_LO = 5;
  localparam int SEL_HI = 4;
  localparam int SEL_LO = 0;
  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic NP_RST = 1'b0;
  localparam logic FAULT_RST = 1'b0;
  localparam logic [3:0] RSVD_RST = 4'h0;
  localparam logic [3:0] TECH_RST = 4'hF;
  localparam logic [4:0] SEL_RST = 5'h01;
  localparam logic [3:0] STATUS_ABILITY = 4'hF;
endpackage
`default_nettype wire

// >>> hw/autoneg_advertisement_register.sv
// auto-negotiation advertisement register with axi4-lite slave port
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module autoneg_advertisement_register
  import adv_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_pin_a,
  input wire logic autoneg_select_pin,
  input wire logic rate_select_pin,
  input wire logic duplex_select_pin,
  input wire logic command_override,
  input wire logic link_fault,
  input wire logic autoneg_enable_ctrl,
  input wire logic rate_select_ctrl,
  input wire logic duplex_select_ctrl,
  output logic [15:0] link_code_word,
  output logic [3:0] reserved_aux,
  output logic autoneg_run,
  output logic speed_100,
  output logic full_duplex,
  output logic [3:0] status_ability
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
    logic np;
    logic fault;
    logic [3:0] rsvd;
    logic [3:0] tech;
    logic [4:0] sel;
    logic [15:0] lcw;
    logic an_run;
    logic spd100;
    logic fdx;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  default clocking check_clock @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // bit order of sync: 3 mode, 2 autoneg, 1 rate, 0 duplex
  logic hw_mode;
  logic an_pin;
  logic rate_pin;
  logic dpx_pin;
  logic wr_commit;
  logic wr_hit;
  logic [15:0] view;

  assign hw_mode = ~state_r.sync2[3];
  assign an_pin = state_r.sync2[2];
  assign rate_pin = state_r.sync2[1];
  assign dpx_pin = state_r.sync2[0];

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  // one-hot of 100fd, 100hd, 10fd, 10hd from rate and duplex selection
  function automatic logic [3:0] tech_onehot(input logic r100,
                                             input logic fd);
    logic [3:0] v;
    v = 4'h0;
    unique case ({r100, fd})
      2'b11: v = 4'h8;
      2'b10: v = 4'h4;
      2'b01: v = 4'h2;
      2'b00: v = 4'h1;
    endcase
    return v;
  endfunction

  // software view of the word: reserved and t4 always zero
  function automatic logic [15:0] adv_view(input state_t s,
                                           input logic hw,
                                           input logic an,
                                           input logic r100,
                                           input logic fd);
    logic [15:0] v;
    v = 16'h0000;
    v[NP_BIT] = s.np;
    v[FAULT_BIT] = s.fault;
    v[T4_BIT] = 1'b0;
    if (!hw) begin
      v[TECH_HI:TECH_LO] = s.tech;
    end else if (an) begin
      v[TECH_HI:TECH_LO] = tech_onehot(r100, fd);
    end else begin
      // undefined while negotiation is off; shown as zero
      v[TECH_HI:TECH_LO] = 4'h0;
    end
    v[SEL_HI:SEL_LO] = s.sel;
    return v;
  endfunction

  assign view = adv_view(state_r, hw_mode, an_pin, rate_pin, dpx_pin);

  // -------------------------------------------------------------------
  // bus handshakes
  // -------------------------------------------------------------------
  assign s_axi_awready = ~state_r.aw_got & ~state_r.bvalid;
  assign s_axi_wready = ~state_r.w_got & ~state_r.bvalid;
  assign s_axi_arready = ~state_r.rvalid;
  assign wr_commit = state_r.aw_got & state_r.w_got;
  assign wr_hit = wr_commit & (state_r.awaddr == ADV_OFFSET);

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.sync1 = {mode_pin_a, autoneg_select_pin, rate_select_pin,
                       duplex_select_pin};
    state_nxt.sync2 = state_r.sync1;

    if (s_axi_awvalid && s_axi_awready) begin
      state_nxt.aw_got = 1'b1;
      state_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_nxt.w_got = 1'b1;
      state_nxt.wdata = s_axi_wdata[15:0];
      state_nxt.wstrb = s_axi_wstrb[1:0];
    end
    if (state_r.bvalid && s_axi_bready) begin
      state_nxt.bvalid = 1'b0;
    end

    // write takes effect one edge after both halves are held
    if (wr_commit) begin
      state_nxt.aw_got = 1'b0;
      state_nxt.w_got = 1'b0;
      state_nxt.bvalid = 1'b1;
      state_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (wr_hit && state_r.wstrb[1]) begin
      state_nxt.np = state_r.wdata[NP_BIT];
      state_nxt.fault = state_r.wdata[FAULT_BIT];
      if (command_override) begin
        // reserved bits are stored but never read back
        state_nxt.rsvd = {state_r.wdata[RSVD14_BIT],
                          state_r.wdata[RSVD_HI:RSVD_LO]};
        state_nxt.tech[3] = hw_mode ? state_r.tech[3]
                                    : state_r.wdata[TECH_HI];
      end
    end
    if (wr_hit && state_r.wstrb[0] && command_override) begin
      state_nxt.sel = state_r.wdata[SEL_HI:SEL_LO];
      if (!hw_mode) begin
        state_nxt.tech[2:0] = state_r.wdata[TECH_HI-1:TECH_LO];
      end
    end
    // local fault wins over a clearing write
    if (link_fault) begin
      state_nxt.fault = 1'b1;
    end else if (!wr_hit || !state_r.wstrb[1]) begin
      state_nxt.fault = 1'b0;
    end

    if (state_r.rvalid && s_axi_rready) begin
      state_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      state_nxt.rvalid = 1'b1;
      if (s_axi_araddr == ADV_OFFSET) begin
        state_nxt.rdata = view;
        state_nxt.rresp = RESP_OKAY;
      end else begin
        state_nxt.rdata = 16'h0000;
        state_nxt.rresp = RESP_SLVERR;
      end
    end

    state_nxt.lcw = view;
    if (hw_mode) begin
      state_nxt.an_run = an_pin;
      state_nxt.spd100 = rate_pin;
      state_nxt.fdx = dpx_pin;
    end else begin
      state_nxt.an_run = autoneg_enable_ctrl;
      state_nxt.spd100 = rate_select_ctrl;
      state_nxt.fdx = duplex_select_ctrl;
    end
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= '0;
      state_r.np <= NP_RST;
      state_r.fault <= FAULT_RST;
      state_r.rsvd <= RSVD_RST;
      state_r.tech <= TECH_RST;
      state_r.sel <= SEL_RST;
      state_r.bresp <= RESP_OKAY;
      state_r.rresp <= RESP_OKAY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign s_axi_bvalid = state_r.bvalid;
  assign s_axi_bresp = state_r.bresp;
  assign s_axi_rvalid = state_r.rvalid;
  assign s_axi_rresp = state_r.rresp;
  assign s_axi_rdata = {16'h0000, state_r.rdata};
  assign link_code_word = state_r.lcw;
  assign reserved_aux = state_r.rsvd;
  assign autoneg_run = state_r.an_run;
  assign speed_100 = state_r.spd100;
  assign full_duplex = state_r.fdx;
  // advertised bits never narrow the reported capabilities
  assign status_ability = STATUS_ABILITY;

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  sequence gated_write_s;
    wr_hit && !command_override;
  endsequence

  sequence low_open_write_s;
    wr_hit && state_r.wstrb[0] && command_override;
  endsequence

  sequence write_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence hw_an_steady_s;
    hw_mode && an_pin && $stable(state_r.sync2) [*2];
  endsequence

  a_unmapped_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr != ADV_OFFSET
    |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");

  a_write_answer: assert property (
    write_taken_s |=> ##1 s_axi_bvalid)
    else $error("write response not two cycles after request");

  a_write_release: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after acceptance");

  a_np_write: assert property (
    wr_hit && state_r.wstrb[1]
    |=> state_r.np == $past(state_r.wdata[NP_BIT]))
    else $error("next page bit did not take write");

  a_rsvd14_gate: assert property (
    gated_write_s |=> $stable(state_r.rsvd[3]))
    else $error("bit 14 changed without override");

  a_rsvd_read_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[14] == 1'b0 && s_axi_rdata[12:10] == 3'h0)
    else $error("reserved bits read nonzero");

  a_rsvd_low_gate: assert property (
    gated_write_s |=> $stable(state_r.rsvd[2:0]))
    else $error("bits 12 to 10 changed without override");

  a_fault_to_word: assert property (
    link_fault |-> ##2 link_code_word[FAULT_BIT])
    else $error("fault not carried in link code word");

  a_fault_clear: assert property (
    !link_fault && !(wr_hit && state_r.wstrb[1]) |=> !state_r.fault)
    else $error("fault flag not cleared without a fault");

  a_t4_zero: assert property (
    link_code_word[T4_BIT] == 1'b0 && !(s_axi_rvalid && s_axi_rdata[9]))
    else $error("t4 ability advertised");

  a_tech_ro_hw: assert property (
    wr_commit && hw_mode |=> $stable(state_r.tech))
    else $error("ability bits written in hardware mode");

  a_hw_forced: assert property (
    hw_mode && !an_pin |=> !autoneg_run && speed_100 == $past(rate_pin))
    else $error("hardware forced mode wrong");

  a_hw_onehot: assert property (
    hw_an_steady_s |=> $onehot(link_code_word[TECH_HI:TECH_LO])
      && link_code_word[TECH_HI:TECH_LO] == $past(view[TECH_HI:TECH_LO]))
    else $error("hardware mode ability not one-hot");

  a_status_const: assert property (
    status_ability == STATUS_ABILITY)
    else $error("status ability changed");

  a_sel_gate: assert property (
    gated_write_s |=> $stable(state_r.sel))
    else $error("selector changed without override");

  a_sel_write: assert property (
    low_open_write_s
    |=> state_r.sel == $past(state_r.wdata[SEL_HI:SEL_LO]))
    else $error("selector did not take write");

  a_sw_forced: assert property (
    !hw_mode && !autoneg_enable_ctrl
    |=> !autoneg_run && full_duplex == $past(duplex_select_ctrl))
    else $error("software forced mode wrong");

  a_tech_gate: assert property (
    gated_write_s |=> $stable(state_r.tech))
    else $error("ability bits changed without override");

endmodule
`default_nettype wire

// >>> test/station_manager.sv
// station manager model: axi4-lite master issuing register cycles
`timescale 1ns/10ps
`default_nettype none
module station_manager
  import adv_pkg::*;
(
  input wire logic clock,
  output logic [ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // -------------------------------------------------------------------
  // bus cycles, entered just after a rising edge
  // -------------------------------------------------------------------
  // handshakes looked at on the falling edge: the slave only moves on
  // rising edges, so this is what the next rising edge will see
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r, input logic [3:0] s = 4'hF);
    logic ha, hw, hb;
    ha = 0;
    hw = 0;
    hb = 0;
    // spare edge: the previous release must not share a step with this
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb) begin
      @(negedge clock);
      if (awvalid && awready) ha = 1;
      if (wvalid && wready) hw = 1;
      hb = bvalid;
      r = bresp;
      @(posedge clock);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ha, hb;
    ha = 0;
    hb = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hb) begin
      @(negedge clock);
      if (arvalid && arready) ha = 1;
      hb = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ha) arvalid <= 1'b0;
      if (hb) rready <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> test/autoneg_advertisement_register_bench.sv
// self-checking bench for the advertisement register block
`timescale 1ns/10ps
`default_nettype none
module autoneg_advertisement_register_bench
  import adv_pkg::*;
;
  logic clock = 0, reset_n = 0;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, reserved_aux, status_ability;
  logic [1:0] bresp, rresp, r;
  logic mode_pin_a = 1, autoneg_select_pin = 1, rate_select_pin = 0;
  logic duplex_select_pin = 0, command_override = 0, link_fault = 0;
  logic autoneg_enable_ctrl = 1, rate_select_ctrl = 0;
  logic duplex_select_ctrl = 0, autoneg_run, speed_100, full_duplex;
  logic [15:0] link_code_word;
  int miscompares = 0, total_checks = 0, cycles = 0;
  autoneg_advertisement_register uut(.clock, .reset_n,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .mode_pin_a, .autoneg_select_pin,
    .rate_select_pin, .duplex_select_pin, .command_override, .link_fault,
    .autoneg_enable_ctrl, .rate_select_ctrl, .duplex_select_ctrl,
    .link_code_word, .reserved_aux, .autoneg_run, .speed_100,
    .full_duplex, .status_ability);
  station_manager mgr(.clock, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  initial begin
    forever #4 clock = ~clock;
  end
  // -------------------------------------------------------------------
  // shared helpers
  // -------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bench limit: whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic t_reset;
    mgr.rd(ADV_OFFSET, d, r);
    chk("reset word", 32'h000001E1, d);
    chk("code word", 32'h000001E1, link_code_word);
    chk("ability", 32'h0000000F, status_ability);
  endtask
  // next page, reserved, t4 and selector bits 4..1 set, fault and ability bits cleared
  task automatic t_gate;
    mgr.wr(ADV_OFFSET, 32'h0000DE1E, r);
    chk("bresp", RESP_OKAY, r);
    mgr.rd(ADV_OFFSET, d, r);
    chk("gated word", 32'h000081E1, d);
    chk("gated aux", 32'h0, reserved_aux);
    command_override <= 1'b1;
    mgr.wr(ADV_OFFSET, 32'h0000DE1E, r);
    mgr.rd(ADV_OFFSET, d, r);
    chk("open word", 32'h0000801E, d);
    chk("open aux", 32'h0000000F, reserved_aux);
    // byte lanes: low lane alone, then high lane alone
    mgr.wr(ADV_OFFSET, 32'h0000FFFF, r, 4'h1);
    mgr.rd(ADV_OFFSET, d, r);
    chk("low lane", 32'h000080FF, d);
    chk("low lane aux", 32'h0000000F, reserved_aux);
    mgr.wr(ADV_OFFSET, 32'h00000100, r, 4'h2);
    mgr.rd(ADV_OFFSET, d, r);
    chk("high lane", 32'h000001FF, d);
    chk("high lane aux", 32'h0, reserved_aux);
    mgr.wr(ADV_OFFSET, 32'h000001E1, r);
    mgr.rd(ADV_OFFSET, d, r);
    chk("restored", 32'h000001E1, d);
    chk("restored aux", 32'h0, reserved_aux);
  endtask
  task automatic t_hw;
    mode_pin_a <= 1'b0;
    // let the mode pin cross the synchroniser before the write commits
    repeat (3) @(posedge clock);
    mgr.wr(ADV_OFFSET, 32'h00000001, r);
    for (int i = 0; i < 4; i++) begin
      {rate_select_pin, duplex_select_pin} <= i[1:0];
      repeat (5) @(posedge clock);
      mgr.rd(ADV_OFFSET, d, r);
      chk("one hot", 32'h1 | (32'h1 << (5 + i)), d);
      chk("hw run", 32'h1, autoneg_run);
      chk("hw rate", i[1], speed_100);
      chk("hw duplex", i[0], full_duplex);
    end
    autoneg_select_pin <= 1'b0;
    repeat (5) @(posedge clock);
    mgr.rd(ADV_OFFSET, d, r);
    chk("no neg word", 32'h00000001, d);
    chk("no neg run", 32'h0, autoneg_run);
    chk("fixed rate", 32'h1, speed_100);
    chk("fixed duplex", 32'h1, full_duplex);
  endtask
  task automatic t_sw;
    mode_pin_a <= 1'b1;
    autoneg_enable_ctrl <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      {rate_select_ctrl, duplex_select_ctrl} <= i[1:0];
      repeat (5) @(posedge clock);
      chk("sw run", 32'h0, autoneg_run);
      chk("sw rate", i[1], speed_100);
      chk("sw duplex", i[0], full_duplex);
    end
    mgr.rd(ADV_OFFSET, d, r);
    chk("hw write held", 32'h000001E1, d);
  endtask
  task automatic t_fault;
    link_fault <= 1'b1;
    repeat (3) @(posedge clock);
    mgr.rd(ADV_OFFSET, d, r);
    chk("fault set", 32'h000021E1, d);
    chk("fault sent", 32'h1, link_code_word[FAULT_BIT]);
    link_fault <= 1'b0;
    repeat (3) @(posedge clock);
    mgr.rd(ADV_OFFSET, d, r);
    chk("fault clear", 32'h000001E1, d);
  endtask
  task automatic t_unmapped;
    mgr.wr(8'h08, 32'h0, r);
    chk("wr resp", RESP_SLVERR, r);
    mgr.rd(8'h08, d, r);
    chk("rd resp", RESP_SLVERR, r);
    chk("rd data", 32'h0, d);
    mgr.rd(ADV_OFFSET, d, r);
    chk("untouched", 32'h000001E1, d);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset;
    t_gate;
    t_hw;
    t_sw;
    t_fault;
    t_unmapped;
    tally_and_finish;
  end
endmodule
`default_nettype wire
